// file: iqcm_pkg.sv
// Constants shared by the congestion monitor design files.
// Assumes a 32-bit APB port; fields are given LSB first.
package iqcm_pkg;

    // ------------------------------
    // Register map (byte addresses)
    // ------------------------------
    localparam logic [19:0] IQCM_OFF_THRESH   = 20'h13090; // Fill level and divisor
    localparam logic [19:0] IQCM_OFF_STATUS   = 20'h13094; // Hit count and limit
    localparam logic [19:0] IQCM_OFF_TIME     = 20'h13098; // Congested time count
    localparam logic [19:0] IQCM_OFF_INT_STAT = 20'h130A8; // Sticky event bits
    localparam logic [19:0] IQCM_OFF_INT_MASK = 20'h130AC; // Event enables

    // ------------------------------
    // Field layout
    // ------------------------------
    localparam int IQCM_HIT_COUNT_LSB = 16; // Depth hit count, bits [31:16]
    localparam int IQCM_HIT_LIMIT_LSB = 0;  // Hit count limit, bits [15:0]
    localparam int IQCM_DIVISOR_LSB   = 16; // Time tick divisor, bits [31:16]
    localparam int IQCM_FILL_LSB      = 12; // Fill level threshold, bits [15:12]
    localparam int IQCM_FILL_W        = 4;  // Width of the threshold field
    localparam int IQCM_INT_ALERT     = 0;  // Inbound fill alert event bit
    localparam int IQCM_INT_TIME_SAT  = 1;  // Congested time saturated event bit
    localparam int IQCM_INT_W         = 2;  // Number of event bits

    // ------------------------------
    // Values
    // ------------------------------
    localparam logic [15:0] IQCM_HIT_MAX      = 16'hFFFF;       // Hit count ceiling
    localparam logic [31:0] IQCM_TIME_MAX     = 32'h0000FFFF;   // Time count ceiling
    localparam logic [3:0]  IQCM_FILL_OFF     = 4'h0;           // Monitoring off
    localparam logic [3:0]  IQCM_FILL_RSVD    = 4'h8;           // First reserved code
    localparam logic [31:0] IQCM_RESET_VALUE  = 32'h00000000;   // All registers

endpackage : iqcm_pkg

// file: iqcm_sat_counter.sv
// Saturating up/down counter with a software load and a clear.
// Assumes controls come from logic on clk.
`timescale 1ns/1ps

module iqcm_sat_counter
    import iqcm_pkg::*;
#(
    parameter int               WIDTH = 16,
    parameter logic [WIDTH-1:0] MAX   = '1
) (
    // Clock and control
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             ce,
    // Controls, in falling priority
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] loadValue,
    input  wire logic             clear,
    input  wire logic             inc,
    input  wire logic             dec,
    // Result
    output logic      [WIDTH-1:0] count
);

    // --------------------------------------------------------------------
    // Elaboration check
    // --------------------------------------------------------------------
    if (WIDTH < 2) begin : g_bad_width
        $error("iqcm_sat_counter: WIDTH must be at least 2");
    end

    // --------------------------------------------------------------------
    // Counter
    // --------------------------------------------------------------------
    // An increment that meets a clear is kept, so no event is lost
    always_ff @(posedge clk) begin
        if (!nrst) begin
            count <= '0;
        end else if (ce) begin
            if (load) begin
                count <= loadValue;
            end else if (clear) begin
                count <= inc ? WIDTH'(1) : '0;
            end else if (inc && !dec && count < MAX) begin
                count <= count + WIDTH'(1);
            end else if (dec && !inc && count != '0) begin
                count <= count - WIDTH'(1);
            end
        end
    end

endmodule // iqcm_sat_counter

// file: iqcm_tick_divider.sv
// Cycle divider: one tick every N cycles of continuous run, N = divisor.
// Assumes run and divisor come from logic on clk.
`timescale 1ns/1ps

module iqcm_tick_divider
    import iqcm_pkg::*;
#(
    parameter int WIDTH = 16
) (
    // Clock and control
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             ce,
    // Divider inputs
    input  wire logic             run,
    input  wire logic [WIDTH-1:0] divisor,
    // One-cycle tick
    output logic                  tick
);

    if (WIDTH < 1) begin : g_bad_width
        $error("iqcm_tick_divider: WIDTH must be at least 1");
    end

    logic [WIDTH-1:0] phase; // Cycles spent in the current period

    // A zero divisor never ticks
    assign tick = ce && run && divisor != '0 && phase == divisor - WIDTH'(1);

    // --------------------------------------------------------------------
    // Phase counter
    // --------------------------------------------------------------------
    // Restarts whenever run drops, so only continuous runs count
    always_ff @(posedge clk) begin
        if (!nrst) begin
            phase <= '0;
        end else if (ce) begin
            if (!run || tick || divisor == '0) begin
                phase <= '0;
            end else begin
                phase <= phase + WIDTH'(1);
            end
        end
    end

endmodule // iqcm_tick_divider

// file: iqcm_monitor.sv
// Input queue congestion monitor for one switch port: APB registers,
// two counters and a level interrupt.
// Assumes queue fill, packet strobe and leak tick come from logic on clk.
`timescale 1ns/1ps

// Behaviour
// - Congested when buffers in use reach threshold
// - Count packet arrivals while congested
// - Depth hit count saturates at all ones
// - Software writes preset both counters
// - Clearing fill alert zeroes hit count
// - Zero hit limit disables hit counting
// - Unread hit count decrements each leak period
// - Hit count reaching limit raises alert
// - Hit count high half, limit low half
// - Time count steps every N congested cycles
// - Zero divisor stops the time count
// - Time count stops at its maximum
// - Reading time count returns then clears it
// - Divisor one ticks each cycle, all-ones 65535
// - Fill setting k means k plus one
module iqcm_monitor
    import iqcm_pkg::*;
#(
    parameter int ADDR_W = 20, // APB address width
    parameter int FILL_W = 4   // Width of the buffers-in-use count
) (
    // Clock, reset and enable
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic              ce,
    // APB slave
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Input queue observation
    input  wire logic [FILL_W-1:0] bufsInUse,
    input  wire logic              pktReceived,
    input  wire logic              leakPeriodTick,
    // Results
    output logic                   congested,
    output logic                   irq
);

    // --------------------------------------------------------------------
    // Elaboration checks
    // --------------------------------------------------------------------
    if (ADDR_W < 17) begin : g_bad_addr
        $error("iqcm_monitor: ADDR_W too small for the register map");
    end
    if (FILL_W < IQCM_FILL_W) begin : g_bad_fill
        $error("iqcm_monitor: FILL_W cannot hold a fill of eight");
    end

    // --------------------------------------------------------------------
    // Declarations
    // --------------------------------------------------------------------
    logic [15:0]           timeDivisor;    // Cycles per congested time step
    logic [IQCM_FILL_W-1:0] fillLevel;     // Fill level threshold setting
    logic [15:0]           hitLimit;       // Hit count limit
    logic [15:0]           hitCount;       // Depth hit count
    logic [31:0]           timeCount;      // Congested time count
    logic [IQCM_INT_W-1:0] intStatus;      // Sticky event bits
    logic [IQCM_INT_W-1:0] intMask;        // Event enables
    logic                  readSinceLeak;  // Hit count read this leak period
    logic                  rdValid;        // prdata holds the answer
    logic                  nowCongested;   // Combinational congestion state
    logic                  timeTick;       // Time step from the divider
    logic [FILL_W-1:0]     fillNeeded;     // Buffers that mean congestion
    logic                  capture;        // Read data being latched
    logic                  wrDone;         // Write completes this edge
    logic                  selThresh;      // Address decodes
    logic                  selStatus;
    logic                  selTime;
    logic                  selIntStat;
    logic                  selIntMask;
    logic                  mapped;         // Any register addressed
    logic                  alertClear;     // Written one to the alert bit
    logic                  hitEvent;       // Hit count at or past limit
    logic                  hitInc;         // Packet arrival to count
    logic                  hitDec;         // Leak decrement due
    logic [31:0]           next_prdata;    // Read mux

    // --------------------------------------------------------------------
    // Address decode and handshake
    // --------------------------------------------------------------------
    assign selThresh  = paddr == ADDR_W'(IQCM_OFF_THRESH);
    assign selStatus  = paddr == ADDR_W'(IQCM_OFF_STATUS);
    assign selTime    = paddr == ADDR_W'(IQCM_OFF_TIME);
    assign selIntStat = paddr == ADDR_W'(IQCM_OFF_INT_STAT);
    assign selIntMask = paddr == ADDR_W'(IQCM_OFF_INT_MASK);
    assign mapped     = selThresh | selStatus | selTime | selIntStat | selIntMask;

    // Read data is latched one edge before the answer, so prdata is a flop
    assign capture = ce && psel && !rdValid;
    // Ready waits for the latch; a frozen block holds the bus
    assign pready  = ce && psel && penable && rdValid;
    assign pslverr = pready && !mapped;
    assign wrDone  = pready && pwrite && mapped;

    // Tracks whether prdata already holds this transfer's answer
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rdValid <= 1'b0;
        end else if (ce) begin
            if (pready) begin
                rdValid <= 1'b0;
            end else if (capture) begin
                rdValid <= 1'b1;
            end
        end
    end

    // Read mux; reserved and unmapped bits read as zero
    always_comb begin
        next_prdata = IQCM_RESET_VALUE;
        if (selThresh) begin
            next_prdata[IQCM_DIVISOR_LSB +: 16]        = timeDivisor;
            next_prdata[IQCM_FILL_LSB +: IQCM_FILL_W]  = fillLevel;
        end else if (selStatus) begin
            next_prdata[IQCM_HIT_COUNT_LSB +: 16] = hitCount;
            next_prdata[IQCM_HIT_LIMIT_LSB +: 16] = hitLimit;
        end else if (selTime) begin
            next_prdata = timeCount;
        end else if (selIntStat) begin
            next_prdata[IQCM_INT_W-1:0] = intStatus;
        end else if (selIntMask) begin
            next_prdata[IQCM_INT_W-1:0] = intMask;
        end
    end

    // Read data register, latched once per transfer
    always_ff @(posedge clk) begin
        if (!nrst) begin
            prdata <= IQCM_RESET_VALUE;
        end else if (capture) begin
            prdata <= pwrite ? IQCM_RESET_VALUE : next_prdata;
        end
    end

    // --------------------------------------------------------------------
    // Configuration registers
    // --------------------------------------------------------------------
    // Threshold register: divisor and fill level
    always_ff @(posedge clk) begin
        if (!nrst) begin
            timeDivisor <= '0;
            fillLevel   <= '0;
        end else if (ce && wrDone && selThresh) begin
            timeDivisor <= pwdata[IQCM_DIVISOR_LSB +: 16];
            fillLevel   <= pwdata[IQCM_FILL_LSB +: IQCM_FILL_W];
        end
    end

    // Hit limit shares the status word with the hit count
    always_ff @(posedge clk) begin
        if (!nrst) begin
            hitLimit <= '0;
        end else if (ce && wrDone && selStatus) begin
            hitLimit <= pwdata[IQCM_HIT_LIMIT_LSB +: 16];
        end
    end

    // Interrupt mask
    always_ff @(posedge clk) begin
        if (!nrst) begin
            intMask <= '0;
        end else if (ce && wrDone && selIntMask) begin
            intMask <= pwdata[IQCM_INT_W-1:0];
        end
    end

    // --------------------------------------------------------------------
    // Congestion detection
    // --------------------------------------------------------------------
    // Setting k needs k+1 buffers; off and reserved codes never match
    assign fillNeeded   = FILL_W'(fillLevel) + FILL_W'(1);
    assign nowCongested = fillLevel != IQCM_FILL_OFF
                       && fillLevel < IQCM_FILL_RSVD
                       && bufsInUse >= fillNeeded;

    // Registered copy for the outside world
    always_ff @(posedge clk) begin
        if (!nrst) begin
            congested <= 1'b0;
        end else if (ce) begin
            congested <= nowCongested;
        end
    end

    // --------------------------------------------------------------------
    // Depth hit count
    // --------------------------------------------------------------------
    assign alertClear = wrDone && selIntStat && pwdata[IQCM_INT_ALERT];
    // Counting is off while the limit is zero
    assign hitInc = pktReceived && nowCongested && hitLimit != '0;
    assign hitDec = leakPeriodTick && !readSinceLeak;

    // Notes whether software looked at the count in this leak period;
    // a read landing on the leak tick counts for the next period
    always_ff @(posedge clk) begin
        if (!nrst) begin
            readSinceLeak <= 1'b0;
        end else if (ce) begin
            if (capture && !pwrite && selStatus) begin
                readSinceLeak <= 1'b1;
            end else if (leakPeriodTick) begin
                readSinceLeak <= 1'b0;
            end
        end
    end

    iqcm_sat_counter #(
        .WIDTH (16),
        .MAX   (IQCM_HIT_MAX)
    ) u_hit_count (
        .clk       (clk),
        .nrst      (nrst),
        .ce        (ce),
        .load      (wrDone && selStatus),
        .loadValue (pwdata[IQCM_HIT_COUNT_LSB +: 16]),
        .clear     (alertClear),
        .inc       (hitInc),
        .dec       (hitDec),
        .count     (hitCount)
    );

    // --------------------------------------------------------------------
    // Congested time count
    // --------------------------------------------------------------------
    // Divider restarts when congestion breaks, so steps need a run of N
    iqcm_tick_divider #(
        .WIDTH (16)
    ) u_time_tick (
        .clk     (clk),
        .nrst    (nrst),
        .ce      (ce),
        .run     (nowCongested),
        .divisor (timeDivisor),
        .tick    (timeTick)
    );

    // Read-clear happens as the answer is latched, so no step is lost
    // between the value shown and the clear
    iqcm_sat_counter #(
        .WIDTH (32),
        .MAX   (IQCM_TIME_MAX)
    ) u_time_count (
        .clk       (clk),
        .nrst      (nrst),
        .ce        (ce),
        .load      (wrDone && selTime),
        .loadValue (pwdata),
        .clear     (capture && !pwrite && selTime),
        .inc       (timeTick),
        .dec       (1'b0),
        .count     (timeCount)
    );

    // --------------------------------------------------------------------
    // Interrupt status and output
    // --------------------------------------------------------------------
    assign hitEvent = hitLimit != '0 && hitCount >= hitLimit;

    // Sticky bits; a set in the clearing cycle wins over the clear
    always_ff @(posedge clk) begin
        if (!nrst) begin
            intStatus <= '0;
        end else if (ce) begin
            if (wrDone && selIntStat) begin
                intStatus <= intStatus & ~pwdata[IQCM_INT_W-1:0];
            end
            if (hitEvent) begin
                intStatus[IQCM_INT_ALERT] <= 1'b1;
            end
            if (timeCount >= IQCM_TIME_MAX) begin
                intStatus[IQCM_INT_TIME_SAT] <= 1'b1;
            end
        end
    end

    // Level interrupt while any enabled event is pending
    assign irq = |(intStatus & intMask);

endmodule // iqcm_monitor

// file: iqcm_monitor_sva.sv
// Port-level checker for the congestion monitor.
// Assumes one clock and the monitor's zero-wait APB answer.
`timescale 1ns/1ps

module iqcm_monitor_sva
    import iqcm_pkg::*;
#(
    parameter int ADDR_W = 20, // APB address width
    parameter int FILL_W = 4   // Buffers-in-use width
) (
    // Clock, reset, enable
    input wire logic              clk,
    input wire logic              nrst,
    input wire logic              ce,
    // APB
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    // Queue and results
    input wire logic [FILL_W-1:0] bufsInUse,
    input wire logic              congested,
    input wire logic              irq
);
    // ------------------------------
    // Helpers
    // ------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    logic done;   // Transfer completes this cycle
    logic mapped; // Address hits a register
    always_comb begin
        done = psel && penable && pready;
        mapped = paddr inside {ADDR_W'(IQCM_OFF_THRESH), ADDR_W'(IQCM_OFF_STATUS),
            ADDR_W'(IQCM_OFF_TIME), ADDR_W'(IQCM_OFF_INT_STAT), ADDR_W'(IQCM_OFF_INT_MASK)};
    end

    // ------------------------------
    // Assertions
    // ------------------------------
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("pready outside an access phase");
    a_zero_wait: assert property (ce && psel && !penable ##1 ce && psel && penable |-> pready)
        else $error("access phase was not answered at once");
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready held for two cycles");
    a_unmapped_err: assert property (done |-> pslverr == !mapped)
        else $error("pslverr does not match the address decode");
    a_err_reads_zero: assert property (done && !pwrite && pslverr |-> prdata == 32'h0)
        else $error("unmapped read returned data");
    a_write_zero: assert property (done && pwrite |-> prdata == 32'h0)
        else $error("write transfer returned data");
    // Read data changes only at a capture edge
    a_data_held: assert property (!psel |=> $stable(prdata))
        else $error("prdata changed without a request");
    a_low_fill_idle: assert property (ce && bufsInUse < FILL_W'(2) |=> !congested)
        else $error("congested with fewer than two buffers");
    a_mask_off_quiet: assert property (done && pwrite && paddr == ADDR_W'(IQCM_OFF_INT_MASK)
        && pwdata[1:0] == 2'b00 |=> !irq)
        else $error("irq high with every event masked");
    // Reset is the antecedent, so it is no disable
    a_reset_quiet: assert property (disable iff (1'b0)
        !nrst |=> !pready && !irq && !congested && prdata == 32'h0)
        else $error("outputs not quiet after reset");

    cover property (done && pslverr);
    cover property ($rose(irq));
    cover property ($rose(congested));

endmodule // iqcm_monitor_sva

bind iqcm_monitor iqcm_monitor_sva #(.ADDR_W(ADDR_W), .FILL_W(FILL_W)) chk (
    .clk(clk), .nrst(nrst), .ce(ce), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bufsInUse(bufsInUse), .congested(congested), .irq(irq));

// file: iqcm_queue_model.sv
// Model of the receive input queue seen by the monitor.
// Assumes task calls come from one process.
`timescale 1ns/1ps

module iqcm_queue_model
    import iqcm_pkg::*;
#(
    parameter int FILL_W = 4 // Buffers-in-use width
) (
    // Clock
    input wire logic              clk,
    // Queue observation
    output logic     [FILL_W-1:0] bufsInUse,
    output logic                  pktReceived,
    output logic                  leakPeriodTick
);
    // ------------------------------
    // Drivers, all changed just after a rising edge
    // ------------------------------
    initial {bufsInUse, pktReceived, leakPeriodTick} = '0;
    task automatic setFill(input int n);
        @(posedge clk);
        bufsInUse <= FILL_W'(n);
    endtask
    // One single-cycle pulse per packet; a gap keeps pulses apart
    task automatic sendPkt();
        @(posedge clk);
        pktReceived <= 1'b1;
        @(posedge clk);
        pktReceived <= 1'b0;
    endtask
    task automatic leak();
        @(posedge clk);
        leakPeriodTick <= 1'b1;
        @(posedge clk);
        leakPeriodTick <= 1'b0;
    endtask
    // Fill held n cycles, then drained
    task automatic hold(input int b, input int n);
        @(posedge clk);
        bufsInUse <= FILL_W'(b);
        repeat (n) @(posedge clk);
        bufsInUse <= '0;
    endtask
endmodule // iqcm_queue_model

// file: iqcm_monitor_tb_top.sv
// Self-checking bench for the congestion monitor over APB.
// Assumes the queue model and bound checker compile with it.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checkCount++; if ((g) !== (e)) begin errCount++; $display("BAD %s exp %h got %h", nm, e, g); end end

module iqcm_monitor_tb_top
    import iqcm_pkg::*;
();
    // ------------------------------
    // Signals
    // ------------------------------
    logic        clk, nrst, ce;     // 50 MHz clock, sync reset, enable
    logic [19:0] paddr;             // APB address
    logic        psel, penable, pwrite, pready, pslverr;
    logic [31:0] pwdata, prdata, rdv; // rdv holds the last read data
    logic [3:0]  bufsInUse;         // From the queue model
    logic        pktReceived, leakPeriodTick, congested, irq;
    logic        lastErr;           // Last pslverr
    int          errCount = 0;
    int          checkCount = 0;
    int divTab[3] = '{3, 1, 0};  // Divisor, cycles, expected ticks
    int cycTab[3] = '{9, 5, 6};
    int expTab[3] = '{3, 5, 0};
    int offCodes[2] = '{0, 8};   // Fill codes that never congest

    iqcm_monitor #(.ADDR_W(20), .FILL_W(4)) dut (.clk(clk), .nrst(nrst), .ce(ce),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .bufsInUse(bufsInUse),
        .pktReceived(pktReceived), .leakPeriodTick(leakPeriodTick),
        .congested(congested), .irq(irq));
    iqcm_queue_model #(.FILL_W(4)) qm (.clk(clk), .bufsInUse(bufsInUse),
        .pktReceived(pktReceived), .leakPeriodTick(leakPeriodTick));

    // ------------------------------
    // Clock, bus tasks, verdict
    // ------------------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Request held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [19:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        if (n >= 64) errCount++;
        rdv = prdata;
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [19:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [19:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0);
        `CHK(nm, e, rdv)
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checkCount, errCount);
        if (errCount == 0 && checkCount > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Tests take about 260 cycles
    initial begin
        repeat (5000) @(posedge clk);
        errCount++;
        summarize();
    end

    // ------------------------------
    // Tests
    // ------------------------------
    initial begin
        {nrst, ce, psel, penable, pwrite, paddr, pwdata} = '0;
        ce = 1'b1;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        // Reset values and an unmapped read
        rdc(IQCM_OFF_THRESH, 32'h0, "thresh");
        rdc(IQCM_OFF_STATUS, 32'h0, "status");
        rdc(IQCM_OFF_TIME, 32'h0, "time");
        rdc(IQCM_OFF_INT_STAT, 32'h0, "intstat");
        rdc(IQCM_OFF_INT_MASK, 32'h0, "intmask");
        rdc(20'h13000, 32'h0, "unmapped");
        `CHK("slverr", 1'b1, lastErr)
        $display("test reset done");
        // Fill codes 1 to 7 at their edge
        for (int k = 1; k < 8; k++) begin
            wr(IQCM_OFF_THRESH, 32'(k) << IQCM_FILL_LSB);
            qm.setFill(k);
            repeat (2) @(posedge clk);
            `CHK("cong below", 1'b0, congested)
            qm.setFill(k + 1);
            repeat (2) @(posedge clk);
            `CHK("cong at", 1'b1, congested)
        end
        // A low enable freezes the congestion flag
        ce <= 1'b0;
        qm.setFill(0);
        repeat (2) @(posedge clk);
        `CHK("frozen", 1'b1, congested)
        ce <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK("thawed", 1'b0, congested)
        foreach (offCodes[i]) begin
            wr(IQCM_OFF_THRESH, 32'(offCodes[i]) << IQCM_FILL_LSB);
            qm.setFill(15);
            repeat (2) @(posedge clk);
            `CHK("cong off", 1'b0, congested)
        end
        $display("test fill done");
        // Hit counting, alert and mask
        wr(IQCM_OFF_THRESH, 32'h00001000);
        wr(IQCM_OFF_INT_MASK, 32'h1);
        wr(IQCM_OFF_STATUS, 32'h00000003);
        qm.setFill(1);
        qm.sendPkt();
        rdc(IQCM_OFF_STATUS, 32'h00000003, "idle pkt");
        qm.setFill(2);
        qm.sendPkt();
        qm.sendPkt();
        rdc(IQCM_OFF_STATUS, 32'h00020003, "two pkts");
        `CHK("irq early", 1'b0, irq)
        qm.sendPkt();
        repeat (3) @(posedge clk);
        `CHK("irq limit", 1'b1, irq)
        wr(IQCM_OFF_INT_MASK, 32'h0);
        @(posedge clk);
        `CHK("irq masked", 1'b0, irq)
        wr(IQCM_OFF_INT_MASK, 32'h1);
        $display("test count done");
        // Sticky alert, preset, clear by writing one
        wr(IQCM_OFF_STATUS, 32'h00000003);
        rdc(IQCM_OFF_INT_STAT, 32'h1, "sticky");
        wr(IQCM_OFF_STATUS, 32'h00020003);
        wr(IQCM_OFF_INT_STAT, 32'h1);
        rdc(IQCM_OFF_STATUS, 32'h00000003, "w1c clr");
        rdc(IQCM_OFF_INT_STAT, 32'h0, "w1c stat");
        `CHK("irq clr", 1'b0, irq)
        // Zero limit, then saturation
        wr(IQCM_OFF_STATUS, 32'h00050000);
        qm.sendPkt();
        rdc(IQCM_OFF_STATUS, 32'h00050000, "zero lim");
        wr(IQCM_OFF_STATUS, 32'hFFFEFFFF);
        qm.sendPkt();
        qm.sendPkt();
        rdc(IQCM_OFF_STATUS, 32'hFFFFFFFF, "hit sat");
        // Leak: the first tick follows a read, the second does not
        wr(IQCM_OFF_STATUS, 32'h0005000A);
        rdc(IQCM_OFF_STATUS, 32'h0005000A, "leak pre");
        qm.leak();
        qm.leak();
        rdc(IQCM_OFF_STATUS, 32'h0004000A, "leak");
        wr(IQCM_OFF_INT_STAT, 32'h3);
        qm.setFill(0);
        $display("test hit done");
        // Congested time for each divisor
        foreach (divTab[i]) begin
            wr(IQCM_OFF_THRESH, (32'(divTab[i]) << IQCM_DIVISOR_LSB) | 32'h1000);
            rdc(IQCM_OFF_TIME, 32'h0, "time clr");
            qm.hold(2, cycTab[i]);
            rdc(IQCM_OFF_TIME, 32'(expTab[i]), "time");
        end
        wr(IQCM_OFF_THRESH, 32'h00011000);
        rdc(IQCM_OFF_TIME, 32'h0, "time clr");
        wr(IQCM_OFF_TIME, 32'h0000FFFE);
        qm.hold(2, 4);
        rdc(IQCM_OFF_TIME, IQCM_TIME_MAX, "time sat");
        rdc(IQCM_OFF_INT_STAT, 32'h2, "time evt");
        $display("test time done");
        summarize();
    end
endmodule // iqcm_monitor_tb_top
